/* rtl/swc_sleep_wake.sv */
// Sleep entry, wake-up and oscillator start-up sequencing for the core
`include "swc_consts.svh"
module swc_sleep_wake #(
  parameter int N_IRQ    = 8,
  parameter int N_PERIPH = 4
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // Register port
  input  wire logic [`SWC_ADDR_W-1:0]  reg_addr_i,
  input  wire logic [`SWC_DATA_W-1:0]  reg_wdata_i,
  input  wire logic                    reg_write_i,
  input  wire logic                    reg_read_i,
  output logic [`SWC_DATA_W-1:0]       reg_rdata_o,
  // Core side, same clock
  input  wire logic                    sleep_exec_i,
  input  wire logic                    clear_watchdog_i,
  input  wire logic                    global_irq_enable_i,
  input  wire logic [N_IRQ-1:0]        irq_flags_i,
  input  wire logic [N_IRQ-1:0]        irq_enables_i,
  output logic                         core_clk_en_o,
  output swc_pkg::swc_core_ctl_type    core_ctl_o,
  output logic [15:0]                  isr_vector_o,
  output logic                         device_reset_o,
  output logic                         power_down_flag_n_o,
  output logic                         timeout_flag_n_o,
  // Asynchronous sources
  input  wire logic                    ext_irq_pin_i,
  input  wire logic [N_PERIPH-1:0]     periph_irq_i,
  input  wire logic                    external_reset_pin_n_i,
  input  wire logic                    brownout_reset_i,
  input  wire logic                    power_on_reset_i,
  input  wire logic                    low_freq_internal_osc_i,
  input  wire logic                    osc_clk_i,
  // Clock and pad control
  output logic                         low_freq_osc_run_o,
  output logic                         secondary_osc_run_o,
  output logic                         converter_clk_run_o,
  output logic                         cap_sense_osc_run_o,
  output logic                         io_hold_o,
  output logic                         clock_output_pin_o,
  output logic                         clock_output_pin_oe_o
);

  localparam int N_ASYNC = N_PERIPH + 6;

  // Synchroniser bank
  logic [N_ASYNC-1:0] async_in;
  logic [N_ASYNC-1:0] sync1_reg;
  logic [N_ASYNC-1:0] sync2_reg;

  assign async_in = {periph_irq_i, ext_irq_pin_i, external_reset_pin_n_i, brownout_reset_i,
                     power_on_reset_i, low_freq_internal_osc_i, osc_clk_i};

  genvar gi;
  generate
    for (gi = 0; gi < N_ASYNC; gi++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= async_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  logic                osc_s;
  logic                lf_s;
  logic                por_s;
  logic                bor_s;
  logic                ext_rst_n_s;
  logic                ext_irq_s;
  logic [N_PERIPH-1:0] periph_s;

  assign osc_s       = sync2_reg[0];
  assign lf_s        = sync2_reg[1];
  assign por_s       = sync2_reg[2];
  assign bor_s       = sync2_reg[3];
  assign ext_rst_n_s = sync2_reg[4];
  assign ext_irq_s   = sync2_reg[5];
  assign periph_s    = sync2_reg[N_ASYNC-1:6];

  // Rising-edge ticks of the two oscillators
  logic osc_prev_reg;
  logic lf_prev_reg;
  logic osc_tick;
  logic lf_tick;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_prev_reg <= 1'b0;
      lf_prev_reg  <= 1'b0;
    end else begin
      osc_prev_reg <= osc_s;
      lf_prev_reg  <= lf_s;
    end
  end

  assign osc_tick = osc_s && !osc_prev_reg;
  assign lf_tick  = lf_s && !lf_prev_reg;

  // Configuration registers
  swc_pkg::swc_cfg_type         cfg_reg;
  logic [`SWC_WDOG_PS_W-1:0]    wdog_ps_reg;
  swc_pkg::swc_state_type       state_reg;
  swc_pkg::swc_wake_type        wake_cause_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg     <= swc_pkg::swc_cfg_type'(`SWC_CTRL_RST);
      wdog_ps_reg <= `SWC_WDOG_PS_RST;
    end else if (reg_write_i) begin
      if (reg_addr_i == `SWC_OFS_CTRL) begin
        cfg_reg <= swc_pkg::swc_cfg_type'(reg_wdata_i[`SWC_CTRL_W-1:0]);
      end
      if (reg_addr_i == `SWC_OFS_WDOG) begin
        wdog_ps_reg <= reg_wdata_i[`SWC_WDOG_PS_W-1:0];
      end
    end
  end

  function automatic logic crystal_mode(input logic [1:0] mode);
    crystal_mode = (mode != `SWC_OSC_INTERNAL);
  endfunction

  // Reset-class sources behave the same awake or asleep
  logic reset_src;
  assign reset_src = por_s
                   || (cfg_reg.brownout_en && bor_s)
                   || (cfg_reg.ext_reset_en && !ext_rst_n_s);

  // Core interrupt wake needs only the individual enable; external and peripheral wake need none
  logic core_irq;
  logic ext_irq_wake;
  logic periph_wake;
  logic irq_wake;
  assign core_irq     = |(irq_flags_i & irq_enables_i);
  assign ext_irq_wake = ext_irq_s;
  assign periph_wake  = |periph_s;
  assign irq_wake     = core_irq || ext_irq_wake || periph_wake;

  // Watchdog enable per mode
  logic asleep;
  logic wdog_run;
  assign asleep = (state_reg == swc_pkg::SWC_ASLEEP);

  always_comb begin
    case (cfg_reg.watchdog_mode_config)
      `SWC_WDOG_ALWAYS:  wdog_run = 1'b1;
      `SWC_WDOG_NOSLEEP: wdog_run = !asleep;
      `SWC_WDOG_SOFT:    wdog_run = cfg_reg.sw_wdog_en;
      default:           wdog_run = 1'b0;
    endcase
  end

  // Sleep entry decision
  logic sleep_nop;
  logic sleep_enter;
  assign sleep_nop   = sleep_exec_i && core_irq && !global_irq_enable_i;
  assign sleep_enter = sleep_exec_i && !sleep_nop && (state_reg == swc_pkg::SWC_AWAKE);

  // Wake is acted on only on a low-frequency tick; a time-out waits there as pending
  logic wdog_timeout;
  logic pending_wdog_reg;
  logic wake_evt;
  assign wake_evt = asleep && lf_tick && (irq_wake || wdog_timeout || pending_wdog_reg);

  // Oscillator start-up timer
  logic [`SWC_OST_W-1:0] ost_cnt_reg;
  logic                  ost_done;
  assign ost_done = (ost_cnt_reg == `SWC_OST_PERIODS);

  // Sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i || reset_src) begin
      state_reg <= swc_pkg::SWC_AWAKE;
    end else begin
      case (state_reg)
        swc_pkg::SWC_AWAKE: begin
          if (sleep_enter) begin
            state_reg <= swc_pkg::SWC_ASLEEP;
          end
        end
        swc_pkg::SWC_ASLEEP: begin
          if (wake_evt) begin
            if (crystal_mode(cfg_reg.osc_mode)) begin
              state_reg <= swc_pkg::SWC_OST_WAIT;
            end else begin
              state_reg <= swc_pkg::SWC_RESUME;
            end
          end
        end
        swc_pkg::SWC_OST_WAIT: begin
          if (ost_done) begin
            state_reg <= swc_pkg::SWC_RESUME;
          end
        end
        swc_pkg::SWC_RESUME: begin
          state_reg <= swc_pkg::SWC_AWAKE;
        end
        default: begin
          state_reg <= swc_pkg::SWC_AWAKE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || state_reg != swc_pkg::SWC_OST_WAIT) begin
      ost_cnt_reg <= '0;
    end else if (osc_tick && !ost_done) begin
      ost_cnt_reg <= ost_cnt_reg + `SWC_OST_W'(1);
    end
  end

  // Wake cause record
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_cause_reg <= swc_pkg::SWC_WAKE_NONE;
    end else if (asleep && reset_src) begin
      wake_cause_reg <= swc_pkg::SWC_WAKE_RESET;
    end else if (wake_evt) begin
      if (wdog_timeout || pending_wdog_reg) begin
        wake_cause_reg <= swc_pkg::SWC_WAKE_WDOG;
      end else if (ext_irq_wake) begin
        wake_cause_reg <= swc_pkg::SWC_WAKE_EXT_IRQ;
      end else if (periph_wake) begin
        wake_cause_reg <= swc_pkg::SWC_WAKE_PERIPH_IRQ;
      end else begin
        wake_cause_reg <= swc_pkg::SWC_WAKE_CORE_IRQ;
      end
    end
  end

  // Watchdog clear sources
  logic wdog_clear;
  assign wdog_clear = clear_watchdog_i
                   || sleep_enter
                   || wake_evt
                   || (state_reg == swc_pkg::SWC_OST_WAIT)
                   || reset_src;

  swc_watchdog #(
    .CNT_W (`SWC_WDOG_CNT_W)
  ) u_watchdog (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .tick_i     (lf_tick),
    .run_i      (wdog_run),
    .clear_i    (wdog_clear),
    .prescale_i (wdog_ps_reg),
    .timeout_o  (wdog_timeout),
    .count_o    ()
  );

  // Time-out while asleep is held until the next wake tick
  always_ff @(posedge clk_i) begin
    if (rst_i || !asleep) begin
      pending_wdog_reg <= 1'b0;
    end else if (wdog_timeout) begin
      pending_wdog_reg <= 1'b1;
    end
  end

  // Status flags, both active low
  always_ff @(posedge clk_i) begin
    if (rst_i || por_s) begin
      power_down_flag_n_o <= 1'b1;
      timeout_flag_n_o    <= 1'b1;
    end else if (sleep_enter) begin
      power_down_flag_n_o <= 1'b0;
      timeout_flag_n_o    <= 1'b1;
    end else if (wdog_timeout || (wake_evt && pending_wdog_reg)) begin
      timeout_flag_n_o    <= 1'b0;
    end else if (clear_watchdog_i && !asleep) begin
      power_down_flag_n_o <= 1'b1;
      timeout_flag_n_o    <= 1'b1;
    end
  end

  // Reset output: watchdog resets only while awake
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      device_reset_o <= 1'b1;
    end else begin
      device_reset_o <= reset_src || (wdog_timeout && !asleep);
    end
  end

  // Core control
  logic call_isr_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      call_isr_reg <= 1'b0;
    end else if (wake_evt) begin
      call_isr_reg <= global_irq_enable_i && irq_wake && !pending_wdog_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_ctl_o   <= '0;
      isr_vector_o <= '0;
    end else begin
      core_ctl_o.resume        <= (state_reg == swc_pkg::SWC_RESUME);
      core_ctl_o.call_isr      <= (state_reg == swc_pkg::SWC_RESUME) && call_isr_reg;
      core_ctl_o.prefetch_next <= sleep_exec_i;
      isr_vector_o             <= `SWC_ISR_VECTOR;
    end
  end

  assign core_clk_en_o = (state_reg == swc_pkg::SWC_AWAKE);
  assign io_hold_o     = !core_clk_en_o;

  // Oscillators stay alive through sleep; converter clock only when converter_rc_sel is set
  assign low_freq_osc_run_o  = 1'b1;
  assign secondary_osc_run_o = 1'b1;
  assign cap_sense_osc_run_o = 1'b1;
  assign converter_clk_run_o = core_clk_en_o || cfg_reg.converter_rc_sel;

  // Clock output pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_output_pin_o    <= 1'b0;
      clock_output_pin_oe_o <= 1'b0;
    end else begin
      clock_output_pin_o    <= osc_s && core_clk_en_o;
      clock_output_pin_oe_o <= cfg_reg.clock_output_pin_en && !crystal_mode(cfg_reg.osc_mode);
    end
  end

  // Register read port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
    end else if (reg_read_i) begin
      case (reg_addr_i)
        `SWC_OFS_CTRL: reg_rdata_o <= `SWC_DATA_W'(cfg_reg);
        `SWC_OFS_WDOG: reg_rdata_o <= `SWC_DATA_W'(wdog_ps_reg);
        `SWC_OFS_STATUS: begin
          reg_rdata_o                              <= '0;
          reg_rdata_o[`SWC_STAT_PD_N]              <= power_down_flag_n_o;
          reg_rdata_o[`SWC_STAT_TO_N]              <= timeout_flag_n_o;
          reg_rdata_o[`SWC_STAT_ST_LSB+:2]         <= state_reg;
          reg_rdata_o[`SWC_STAT_WK_LSB+:3]         <= wake_cause_reg;
        end
        default: reg_rdata_o <= '0;
      endcase
    end else begin
      reg_rdata_o <= '0;
    end
  end

endmodule // swc_sleep_wake

/* rtl/swc_consts.svh */
// Constants of the sleep and wake controller: offsets, field positions, reset values, counts
//
// Overview of operation
// - Sleep is entered only when the core executes the sleep instruction.
// - Entering sleep clears the watchdog; it keeps counting if enabled in sleep.
// - Entering sleep clears power-down flag and sets the active-low time-out flag.
// - The core clock is stopped while asleep.
// - The low-frequency internal oscillator keeps running during sleep.
// - The secondary timer oscillator keeps running during sleep.
// - Converter runs in sleep on its RC clock; sensing oscillator keeps running.
// - I/O ports hold their drive state throughout sleep.
// - Sleep leaves every reset source except the watchdog unchanged.
// - Wake sources: reset pin, brown-out, power-on, watchdog, external and peripheral interrupts.
// - Pin, brown-out and power-on wakes reset; the others continue execution.
// - The instruction at the next address is prefetched while sleep executes.
// - A core interrupt wakes only if individually enabled, regardless of global enable; external and peripheral interrupts need no enable.
// - After interrupt wake run next instruction, then call the vector if globally enabled.
// - Every wake from sleep clears the watchdog.
// - Enabled flag pending with global interrupts off makes sleep a no-operation.
// - Interrupt during or after sleep completes it, wakes on the next low-frequency tick, updates flags.
// - Crystal modes wait 1024 oscillator periods before resuming; others do not.
// - Crystal modes do not drive the clock output pin.
// - The watchdog stays cleared until the oscillator start-up timer completes.
// - Watchdog time-out in sleep wakes the device instead of resetting it.
// - Watchdog mode 10 runs the watchdog awake and disables it asleep.
`ifndef SWC_CONSTS_SVH
`define SWC_CONSTS_SVH

`define SWC_ADDR_W        4
`define SWC_DATA_W        32
`define SWC_OFS_CTRL      4'h0
`define SWC_OFS_WDOG      4'h4
`define SWC_OFS_STATUS    4'h8

`define SWC_CTRL_W        9
`define SWC_CTRL_RST      9'h000
`define SWC_WDOG_PS_W     5
`define SWC_WDOG_PS_RST   5'h0b
`define SWC_WDOG_BASE     24'h00_0020
`define SWC_WDOG_CNT_W    24

`define SWC_STAT_PD_N     0
`define SWC_STAT_TO_N     1
`define SWC_STAT_ST_LSB   2
`define SWC_STAT_WK_LSB   4

`define SWC_WDOG_ALWAYS   2'h3
`define SWC_WDOG_NOSLEEP  2'h2
`define SWC_WDOG_SOFT     2'h1
`define SWC_OSC_INTERNAL  2'h0

`define SWC_OST_W         11
`define SWC_OST_PERIODS   11'h400
`define SWC_ISR_VECTOR    16'h0004

`endif

/* rtl/swc_pkg.sv */
// Types shared by the sleep and wake controller files
package swc_pkg;

  typedef enum logic [1:0] {
    SWC_AWAKE,
    SWC_ASLEEP,
    SWC_OST_WAIT,
    SWC_RESUME
  } swc_state_type;

  typedef enum logic [2:0] {
    SWC_WAKE_NONE,
    SWC_WAKE_WDOG,
    SWC_WAKE_EXT_IRQ,
    SWC_WAKE_PERIPH_IRQ,
    SWC_WAKE_CORE_IRQ,
    SWC_WAKE_RESET
  } swc_wake_type;

  // Layout of the control register, low bit last
  typedef struct packed {
    logic       clock_output_pin_en;
    logic       brownout_en;
    logic       ext_reset_en;
    logic       converter_rc_sel;
    logic [1:0] osc_mode;
    logic       sw_wdog_en;
    logic [1:0] watchdog_mode_config;
  } swc_cfg_type;

  typedef struct packed {
    logic resume;
    logic call_isr;
    logic prefetch_next;
  } swc_core_ctl_type;

endpackage

/* rtl/swc_watchdog.sv */
// Watchdog counter advanced by low-frequency ticks
`include "swc_consts.svh"
module swc_watchdog #(
  parameter int CNT_W = `SWC_WDOG_CNT_W
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      tick_i,
  input  wire logic                      run_i,
  input  wire logic                      clear_i,
  input  wire logic [`SWC_WDOG_PS_W-1:0] prescale_i,
  output logic                           timeout_o,
  output logic [CNT_W-1:0]               count_o
);

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] limit;

  // Interval is the base period doubled once per prescale step
  assign limit = CNT_W'(`SWC_WDOG_BASE) << prescale_i;

  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i || !run_i) begin
      count_reg <= '0;
      timeout_o <= 1'b0;
    end else if (tick_i) begin
      if (count_reg >= limit - CNT_W'(1)) begin
        count_reg <= '0;
        timeout_o <= 1'b1;
      end else begin
        count_reg <= count_reg + CNT_W'(1);
        timeout_o <= 1'b0;
      end
    end else begin
      timeout_o <= 1'b0;
    end
  end

  assign count_o = count_reg;

endmodule // swc_watchdog

/* verif/swc_sleep_wake_props.sv */
// Concurrent checks on the ports of the sleep and wake controller
module swc_sleep_wake_props #(
  parameter int N_IRQ    = 8,
  parameter int N_PERIPH = 4
) (
  input wire logic                      clk_i,
  input wire logic                      rst_i,
  input wire logic                      sleep_exec_i,
  input wire logic                      global_irq_enable_i,
  input wire logic [N_IRQ-1:0]          irq_flags_i,
  input wire logic [N_IRQ-1:0]          irq_enables_i,
  input wire logic                      core_clk_en_o,
  input wire swc_pkg::swc_core_ctl_type core_ctl_o,
  input wire logic [15:0]               isr_vector_o,
  input wire logic                      device_reset_o,
  input wire logic                      power_down_flag_n_o,
  input wire logic                      timeout_flag_n_o,
  input wire logic                      low_freq_osc_run_o,
  input wire logic                      secondary_osc_run_o,
  input wire logic                      cap_sense_osc_run_o,
  input wire logic                      io_hold_o,
  input wire logic                      clock_output_pin_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic        pend;
  logic [12:0] wait_cnt;
  assign pend = |(irq_flags_i & irq_enables_i);
  // Cycles spent asleep with an enabled interrupt pending
  always_ff @(posedge clk_i) begin
    if (rst_i || core_clk_en_o || !pend) begin
      wait_cnt <= 13'h0000;
    end else begin
      wait_cnt <= wait_cnt + 13'h0001;
    end
  end
  AST_ONLY_BY_SLEEP: assert property ($fell(core_clk_en_o) |-> $past(sleep_exec_i))
    else $error("core clock stopped without a sleep request");
  AST_ENTRY: assert property (sleep_exec_i && core_clk_en_o && !device_reset_o && (global_irq_enable_i || !pend)
    |=> !core_clk_en_o && !power_down_flag_n_o && timeout_flag_n_o)
    else $error("sleep entry wrong");
  AST_NOOP: assert property (sleep_exec_i && core_clk_en_o && !global_irq_enable_i && pend
    |=> core_clk_en_o && $stable(power_down_flag_n_o) && $stable(timeout_flag_n_o))
    else $error("pending interrupt sleep not a no-operation");
  AST_PREFETCH: assert property (sleep_exec_i && core_clk_en_o |=> core_ctl_o.prefetch_next)
    else $error("no prefetch after sleep");
  AST_IO_HOLD: assert property (io_hold_o == !core_clk_en_o)
    else $error("pad hold not matching sleep");
  AST_OSC_RUN: assert property (low_freq_osc_run_o && secondary_osc_run_o && cap_sense_osc_run_o)
    else $error("oscillator stopped");
  AST_RESUME: assert property (core_ctl_o.resume |-> core_clk_en_o && !$past(core_clk_en_o))
    else $error("resume without clock restart");
  AST_CALL_ISR: assert property (core_ctl_o.call_isr |-> core_ctl_o.resume && isr_vector_o == 16'h0004)
    else $error("service call outside resume");
  AST_WAKE_BOUND: assert property (wait_cnt < 13'h0fa0)
    else $error("enabled interrupt did not wake");
  AST_RESET_AWAKE: assert property (device_reset_o |=> core_clk_en_o)
    else $error("reset left core asleep");
  AST_CLOCK_OUTPUT_PIN_QUIET: assert property (!core_clk_en_o |=> !clock_output_pin_o)
    else $error("clock output toggling while asleep");
  COV_NOOP: cover property (sleep_exec_i && core_clk_en_o && pend && !global_irq_enable_i);
  COV_ISR: cover property (core_ctl_o.call_isr);
  COV_RESET: cover property ($rose(device_reset_o));
endmodule // swc_sleep_wake_props

/* verif/swc_core_model.sv */
// Core-side model: free-running oscillators and an asynchronous interrupt pin
module swc_core_model (
  input  wire logic ext_req_i,
  output logic      lf_osc_o,
  output logic      xosc_o,
  output logic      ext_irq_pin_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    lf_osc_o = 1'b0;
    forever #32 lf_osc_o = ~lf_osc_o;
  end
  initial begin
    xosc_o = 1'b0;
    forever #6 xosc_o = ~xosc_o;
  end
  initial ext_irq_pin_o = 1'b0;
  // Pin edge lands off the core clock grid, as a real pad would
  always @(ext_req_i) ext_irq_pin_o <= #5 ext_req_i;
endmodule // swc_core_model

/* verif/swc_sleep_wake_tb_top.sv */
// Self-checking bench for the sleep and wake controller
module swc_sleep_wake_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic                      clk_i, rst_i, reg_write, reg_read, sleep_exec, clr_wd, global_irq_enable, ext_req, bo_rst, xrst_n, por;
  logic                      clk_en, dev_rst, pd_n, to_n, io_hold, conv_run, cko_oe, lf_osc, xosc, ext_pin;
  logic [3:0]                reg_addr, periph;
  logic [31:0]               reg_wdata, reg_rdata;
  logic [7:0]                flags, enables;
  logic [15:0]               vec;
  swc_pkg::swc_core_ctl_type ctl;
  int                        miscompares, n_checks, cycles;

  swc_sleep_wake i_swc_sleep_wake (
    .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_write_i(reg_write), .reg_read_i(reg_read), .reg_rdata_o(reg_rdata),
    .sleep_exec_i(sleep_exec), .clear_watchdog_i(clr_wd), .global_irq_enable_i(global_irq_enable),
    .irq_flags_i(flags), .irq_enables_i(enables), .core_clk_en_o(clk_en), .core_ctl_o(ctl),
    .isr_vector_o(vec), .device_reset_o(dev_rst), .power_down_flag_n_o(pd_n), .timeout_flag_n_o(to_n),
    .ext_irq_pin_i(ext_pin), .periph_irq_i(periph), .external_reset_pin_n_i(xrst_n),
    .brownout_reset_i(bo_rst), .power_on_reset_i(por), .low_freq_internal_osc_i(lf_osc),
    .osc_clk_i(xosc), .low_freq_osc_run_o(), .secondary_osc_run_o(), .converter_clk_run_o(conv_run),
    .cap_sense_osc_run_o(), .io_hold_o(io_hold), .clock_output_pin_o(), .clock_output_pin_oe_o(cko_oe)
  );
  swc_core_model i_swc_core_model (
    .ext_req_i(ext_req), .lf_osc_o(lf_osc), .xosc_o(xosc), .ext_irq_pin_o(ext_pin)
  );

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_i);
    reg_write <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_i);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  task automatic pulse_clr();
    @(posedge clk_i);
    clr_wd <= 1'b1;
    @(posedge clk_i);
    clr_wd <= 1'b0;
  endtask
  task automatic go_sleep();
    @(posedge clk_i);
    sleep_exec <= 1'b1;
    @(posedge clk_i);
    sleep_exec <= 1'b0;
    #1;
  endtask
  task automatic wait_resume(output int n);
    n = 0;
    while (ctl.resume !== 1'b1 && n < 5000) begin
      tick(1);
      n++;
    end
    chk(ctl.resume, 1'h1);
  endtask

  task automatic t_regs();
    rd_chk(4'h0, 32'h0000_0000);
    rd_chk(4'h4, 32'h0000_000b);
    rd_chk(4'h8, 32'h0000_0003);
    rd_chk(4'hc, 32'h0000_0000);
    reg_wr(4'h8, 32'h0000_0000);
    rd_chk(4'h8, 32'h0000_0003);
    reg_wr(4'h4, 32'h0000_0000);
    rd_chk(4'h4, 32'h0000_0000);
    chk(vec, 16'h0004);
  endtask
  task automatic t_noop();
    int n;
    @(posedge clk_i);
    flags   <= 8'h01;
    enables <= 8'h01;
    go_sleep();
    chk({clk_en, pd_n, to_n, ctl.prefetch_next}, 4'hf);
    @(posedge clk_i);
    global_irq_enable <= 1'b1;
    go_sleep();
    chk({clk_en, pd_n, to_n}, 3'h1);
    wait_resume(n);
    @(posedge clk_i);
    flags <= 8'h00;
    pulse_clr();
  endtask
  task automatic t_irq(input logic g);
    int n;
    @(posedge clk_i);
    global_irq_enable     <= g;
    enables <= 8'h01;
    go_sleep();
    chk({clk_en, pd_n, to_n, ctl.prefetch_next}, 4'h3);
    chk({io_hold, conv_run}, 2'h2);
    @(posedge clk_i);
    flags <= 8'h02;
    tick(40);
    chk(clk_en, 1'h0);
    @(posedge clk_i);
    flags <= 8'h03;
    wait_resume(n);
    chk({ctl.call_isr, n < 100}, {g, 1'b1});
    @(posedge clk_i);
    flags <= 8'h00;
    rd_chk(4'h8, 32'h0000_0042);
    pulse_clr();
  endtask
  task automatic t_wdog();
    int n;
    reg_wr(4'h0, 32'h0000_0002);
    go_sleep();
    tick(1500);
    chk(clk_en, 1'h0);
    @(posedge clk_i);
    periph <= 4'h1;
    wait_resume(n);
    @(posedge clk_i);
    periph <= 4'h0;
    reg_wr(4'h0, 32'h0000_0003);
    go_sleep();
    wait_resume(n);
    reg_wr(4'h0, 32'h0000_0000);
    chk({dev_rst, pd_n, to_n}, 3'h0);
    rd_chk(4'h8, 32'h0000_0010);
    pulse_clr();
  endtask
  task automatic t_xtal();
    int n;
    reg_wr(4'h0, 32'h0000_0128);
    tick(3);
    chk(cko_oe, 1'h0);
    go_sleep();
    chk(conv_run, 1'h1);
    @(posedge clk_i);
    ext_req <= 1'b1;
    wait_resume(n);
    chk(n >= 3000, 1'h1);
    @(posedge clk_i);
    ext_req <= 1'b0;
    reg_wr(4'h0, 32'h0000_0100);
    tick(3);
    chk(cko_oe, 1'h1);
    reg_wr(4'h0, 32'h0000_00c0);
    pulse_clr();
  endtask
  task automatic t_bor();
    go_sleep();
    @(posedge clk_i);
    bo_rst <= 1'b1;
    tick(6);
    chk({dev_rst, clk_en}, 2'h3);
    @(posedge clk_i);
    bo_rst <= 1'b0;
    tick(6);
    chk(dev_rst, 1'h0);
    go_sleep();
    @(posedge clk_i);
    xrst_n <= 1'b0;
    tick(6);
    chk({dev_rst, clk_en}, 2'h3);
    @(posedge clk_i);
    xrst_n <= 1'b1;
    tick(6);
    go_sleep();
    @(posedge clk_i);
    por <= 1'b1;
    tick(6);
    chk({dev_rst, clk_en, pd_n, to_n}, 4'hf);
    @(posedge clk_i);
    por <= 1'b0;
    tick(6);
    chk(dev_rst, 1'h0);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Hang guard well above the longest expected run
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    {rst_i, reg_addr, reg_wdata, reg_write, reg_read} = {1'b1, 38'h0};
    {sleep_exec, clr_wd, global_irq_enable, flags, enables, ext_req, bo_rst, periph, por} = 26'h0;
    xrst_n = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(3);
    t_regs();
    t_noop();
    t_irq(1'b0);
    t_irq(1'b1);
    t_wdog();
    t_xtal();
    t_bor();
    complete_run();
  end
endmodule // swc_sleep_wake_tb_top

bind swc_sleep_wake swc_sleep_wake_props #(.N_IRQ(N_IRQ), .N_PERIPH(N_PERIPH)) i_swc_sleep_wake_props (
  .clk_i(clk_i), .rst_i(rst_i), .sleep_exec_i(sleep_exec_i), .global_irq_enable_i(global_irq_enable_i),
  .irq_flags_i(irq_flags_i), .irq_enables_i(irq_enables_i), .core_clk_en_o(core_clk_en_o),
  .core_ctl_o(core_ctl_o), .isr_vector_o(isr_vector_o), .device_reset_o(device_reset_o),
  .power_down_flag_n_o(power_down_flag_n_o), .timeout_flag_n_o(timeout_flag_n_o),
  .low_freq_osc_run_o(low_freq_osc_run_o), .secondary_osc_run_o(secondary_osc_run_o),
  .cap_sense_osc_run_o(cap_sense_osc_run_o), .io_hold_o(io_hold_o),
  .clock_output_pin_o(clock_output_pin_o)
);
